// >>> key_policy_pkg.sv
// ============================================================
// shared constants and types for the key-usage policy unit
package key_policy_pkg;

    // ============================================================
    // final-key-use bitmap geometry
    localparam int BITMAP_FIRST_BYTE = 68;
    localparam int BITMAP_LAST_BYTE = 83;
    localparam int BITMAP_BYTES = BITMAP_LAST_BYTE - BITMAP_FIRST_BYTE + 1;
    localparam int BITMAP_BITS = 8 * BITMAP_BYTES;
    localparam int BYTE_IDX_W = $clog2(BITMAP_BYTES);
    localparam logic [7:0] BYTE_EMPTY = 8'h00;
    localparam logic [7:0] BIT_FIRST_MASK = 8'h80;

    // ============================================================
    // slot and selector decoding
    localparam logic [3:0] FINAL_KEY_SLOT = 4'hF;
    localparam logic [15:0] TRANSPORT_SEL_MIN = 16'h8000;
    localparam logic [3:0] READ_KEY_COPY_ENABLE = 4'h0;
    localparam logic [7:0] MODE_COPY_PLAIN = 8'h01;
    localparam logic [7:0] MODE_COPY_REPLAY = 8'h05;
    localparam int MODE_SOURCE_BIT = 2;
    localparam int SLOT_COUNT = 16;

    // ============================================================
    // widths and reset values
    localparam int KEY_W = 256;
    localparam logic [KEY_W-1:0] TEMP_DATA_RST = '0;

    // ============================================================
    // commands and results
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_MAC_CHECK,
        CMD_DIGEST_GEN,
        CMD_KEY_DERIVE,
        CMD_OTHER_CRYPTO
    } cmd_type;

    typedef enum logic [1:0] {
        RES_OK,
        RES_MISMATCH,
        RES_USE_EXHAUSTED,
        RES_BAD_SELECTOR
    } result_type;

    typedef struct packed {
        cmd_type cmd;
        logic [15:0] selector;
        logic [3:0] parent_slot;
        logic [7:0] mode;
        logic map_secondary;
        logic [KEY_W-1:0] response;
    } request_type;

    typedef struct packed {
        logic source;
        logic generated_data;
        logic check_only;
        logic valid;
    } temp_flags_type;

    localparam temp_flags_type TEMP_FLAGS_RST = '0;

    typedef struct packed {
        logic transport;
        logic [3:0] key_slot;
        logic [15:0] selector;
        logic password_first;
    } hash_req_type;

endpackage

// >>> first_set_finder.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// priority search for the first bit still one, msb of byte 0 first
module first_set_finder #(
    parameter int BYTES = 16,
    parameter int IDX_W = 4
) (
    input wire logic [8*BYTES-1:0] bitmap,
    output logic any_set,
    output logic [IDX_W-1:0] byte_idx,
    output logic [2:0] bit_idx
);

    always_comb begin
        any_set = 1'b0;
        byte_idx = '0;
        bit_idx = '0;
        // walk backwards so the earliest hit is the one that stays
        for (int b = BYTES - 1; b >= 0; b--) begin
            for (int i = 0; i < 8; i++) begin
                if (bitmap[8*b + i]) begin
                    any_set = 1'b1;
                    byte_idx = IDX_W'(b);
                    bit_idx = 3'(i);
                end
            end
        end
    end

endmodule // first_set_finder
`default_nettype wire

// >>> key_usage_policy_unit.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - key 15 limit only when enable set
// - all-zero bitmap makes key 15 error
// - clear first one bit, byte 68 bit 7
// - bitmap can be refilled only while config_locked is low
// - one bit at risk on power loss
// - read and write leave bitmap alone
// - copy function consumes no use bits
// - derive limits parent key, not target
// - copy target is password slot or next
// - copy needs target read-key pointer zero
// - copy needs mode 01/05, source flag match
// - hash stored password then temp nonce
// - on match load target into temp key
// - after copy set temp flags as defined
// - transport selector only for digest generate
// - low four selector bits pick data slot
module key_usage_policy_unit
    import key_policy_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // command in
    input wire logic req_valid,
    output logic req_ready,
    input wire key_policy_pkg::request_type req,
    output logic done,
    output key_policy_pkg::result_type result_q,
    // slot configuration
    input wire logic use_limit_enable,
    input wire logic [4*key_policy_pkg::SLOT_COUNT-1:0] read_key_pointer,
    // personalization of the bitmap while configuration is open
    input wire logic config_locked,
    input wire logic pers_we,
    input wire logic [key_policy_pkg::BYTE_IDX_W-1:0] pers_idx,
    input wire logic [7:0] pers_byte,
    output logic [key_policy_pkg::BITMAP_BITS-1:0] final_key_use_bitmap,
    // hash engine
    output logic hash_start,
    output key_policy_pkg::hash_req_type hash_req_q,
    input wire logic hash_done,
    input wire logic [key_policy_pkg::KEY_W-1:0] hash_digest,
    // data slot read port, data valid one cycle after the strobe
    output logic slot_rd_en,
    output logic [3:0] slot_rd_addr_q,
    input wire logic [key_policy_pkg::KEY_W-1:0] slot_rd_data,
    // temporary key register
    input wire logic temp_load,
    input wire logic [key_policy_pkg::KEY_W-1:0] temp_load_data,
    input wire key_policy_pkg::temp_flags_type temp_load_flags,
    output logic [key_policy_pkg::KEY_W-1:0] temporary_key_register,
    output key_policy_pkg::temp_flags_type temp_flags_q
);

    import key_policy_pkg::*;

    // ============================================================
    // helpers
    function automatic logic is_crypto(input cmd_type c);
        return (c != CMD_READ) && (c != CMD_WRITE);
    endfunction

    function automatic logic [3:0] read_ptr_of(
        input logic [4*SLOT_COUNT-1:0] tbl,
        input logic [3:0] slot
    );
        return tbl[4*slot +: 4];
    endfunction

    // ============================================================
    // state
    typedef enum logic [2:0] {
        S_IDLE,
        S_CHECK,
        S_HASH,
        S_WAIT,
        S_FETCH,
        S_LOAD,
        S_DONE
    } state_type;

    state_type state_q, state_d;
    request_type req_q;
    logic [7:0] bitmap_q [BITMAP_BYTES];
    logic [BITMAP_BITS-1:0] bitmap_flat;
    logic [KEY_W-1:0] temp_data_q;
    result_type result_d;
    logic copy_mode_q;

    // ============================================================
    // decode of the latched command
    logic transport_sel;
    logic bad_selector;
    logic [3:0] data_slot;
    logic [3:0] key_slot;
    logic [3:0] copy_target;
    logic copy_mode;
    logic limit_applies;
    logic any_left;
    logic [BYTE_IDX_W-1:0] hit_byte;
    logic [2:0] hit_bit;
    logic consume;
    logic use_fail;
    logic digest_match;

    assign transport_sel = req_q.selector >= TRANSPORT_SEL_MIN;
    assign bad_selector = transport_sel &&
        (req_q.cmd != CMD_DIGEST_GEN);
    assign data_slot = req_q.selector[3:0];

    // the derive parent is the key that is really used
    assign key_slot = (req_q.cmd == CMD_KEY_DERIVE) ?
        req_q.parent_slot : data_slot;

    // password slot is the selected one; secondary sits one above
    assign copy_target = req_q.map_secondary ?
        4'(data_slot + 4'h1) : data_slot;

    // pointer zero enables copy only with mac check, mode 01/05 and source match; no other slot bit overrides
    assign copy_mode = (req_q.cmd == CMD_MAC_CHECK) &&
        ((req_q.mode == MODE_COPY_PLAIN) ||
         (req_q.mode == MODE_COPY_REPLAY)) &&
        (temp_flags_q.source == req_q.mode[MODE_SOURCE_BIT]) &&
        (read_ptr_of(read_key_pointer, copy_target) ==
         READ_KEY_COPY_ENABLE);

    // read, write and copy never touch the bitmap
    assign limit_applies = use_limit_enable &&
        is_crypto(req_q.cmd) &&
        !copy_mode &&
        !transport_sel &&
        (key_slot == FINAL_KEY_SLOT);

    first_set_finder #(
        .BYTES(BITMAP_BYTES),
        .IDX_W(BYTE_IDX_W)
    ) finder (
        .bitmap(bitmap_flat),
        .any_set(any_left),
        .byte_idx(hit_byte),
        .bit_idx(hit_bit)
    );

    assign use_fail = limit_applies && !any_left;
    assign consume = (state_q == S_CHECK) && clk_en && !bad_selector &&
        limit_applies && any_left;
    assign digest_match = hash_digest == req_q.response;

    // ============================================================
    // final-key-use bitmap
    // no reset: this models nonvolatile storage, and a reset that
    // set it back would hand out fresh uses
    genvar g;
    for (g = 0; g < BITMAP_BYTES; g++) begin : g_flat
        assign bitmap_flat[8*g +: 8] = bitmap_q[g];
    end
    assign final_key_use_bitmap = bitmap_flat;

    always_ff @(posedge clk) begin
        if (clk_en) begin
            if (consume) begin
                // exactly one bit falls per use, so an interrupted
                // command can only leave that one bit in doubt
                bitmap_q[hit_byte] <= bitmap_q[hit_byte] &
                    ~(BIT_FIRST_MASK >> (3'd7 - hit_bit));
            end else if (pers_we && !config_locked) begin
                // only open before lock; no path sets bits later
                bitmap_q[pers_idx] <= pers_byte;
            end
        end
    end

    // ============================================================
    // command sequencer
    always_comb begin
        state_d = state_q;
        result_d = result_q;
        case (state_q)
            S_IDLE: begin
                if (req_valid) begin
                    state_d = S_CHECK;
                end
            end
            S_CHECK: begin
                if (bad_selector) begin
                    result_d = RES_BAD_SELECTOR;
                    state_d = S_DONE;
                end else if (use_fail) begin
                    // abort before any hashing, nothing is modified
                    result_d = RES_USE_EXHAUSTED;
                    state_d = S_DONE;
                end else if (!is_crypto(req_q.cmd)) begin
                    result_d = RES_OK;
                    state_d = S_DONE;
                end else begin
                    state_d = S_HASH;
                end
            end
            S_HASH: begin
                state_d = S_WAIT;
            end
            S_WAIT: begin
                if (hash_done) begin
                    if (!digest_match && req_q.cmd == CMD_MAC_CHECK) begin
                        result_d = RES_MISMATCH;
                        state_d = S_DONE;
                    end else if (copy_mode_q) begin
                        result_d = RES_OK;
                        state_d = S_FETCH;
                    end else begin
                        result_d = RES_OK;
                        state_d = S_DONE;
                    end
                end
            end
            S_FETCH: begin
                state_d = S_LOAD;
            end
            S_LOAD: begin
                state_d = S_DONE;
            end
            S_DONE: begin
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            result_q <= RES_OK;
        end else if (clk_en) begin
            state_q <= state_d;
            result_q <= result_d;
        end
    end

    // ============================================================
    // latched request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_q <= '0;
        end else if (clk_en && state_q == S_IDLE && req_valid) begin
            req_q <= req;
        end
    end

    // copy decision is frozen when the hash is launched so a
    // temp key change meanwhile cannot open the copy path
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            copy_mode_q <= 1'b0;
        end else if (clk_en && state_q == S_CHECK) begin
            copy_mode_q <= copy_mode;
        end
    end

    // ============================================================
    // hash request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hash_req_q <= '0;
        end else if (clk_en && state_q == S_CHECK) begin
            hash_req_q.transport <= transport_sel;
            hash_req_q.key_slot <= key_slot;
            hash_req_q.selector <= req_q.selector;
            hash_req_q.password_first <= copy_mode;
        end
    end

    // ============================================================
    // slot read address for the copy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slot_rd_addr_q <= 4'h0;
        end else if (clk_en && state_q == S_CHECK) begin
            slot_rd_addr_q <= copy_target;
        end
    end

    // ============================================================
    // temporary key register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            temp_data_q <= TEMP_DATA_RST;
            temp_flags_q <= TEMP_FLAGS_RST;
        end else if (clk_en) begin
            if (state_q == S_LOAD) begin
                temp_data_q <= slot_rd_data;
                temp_flags_q.source <= 1'b1;
                temp_flags_q.generated_data <= 1'b0;
                temp_flags_q.check_only <= 1'b0;
                temp_flags_q.valid <= 1'b1;
            end else if (temp_load && state_q == S_IDLE) begin
                // outside loads are dropped, not held, while a command owns the nonce
                temp_data_q <= temp_load_data;
                temp_flags_q <= temp_load_flags;
            end
        end
    end

    assign temporary_key_register = temp_data_q;

    // ============================================================
    // handshakes
    assign req_ready = (state_q == S_IDLE) && clk_en;
    assign hash_start = (state_q == S_HASH) && clk_en;
    assign slot_rd_en = (state_q == S_FETCH) && clk_en;
    assign done = (state_q == S_DONE) && clk_en;

endmodule // key_usage_policy_unit
`default_nettype wire

// >>> key_policy_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checks for the key-usage policy unit
module key_policy_sva
    import key_policy_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire key_policy_pkg::request_type req,
    input wire logic done,
    input wire key_policy_pkg::result_type result_q,
    input wire logic use_limit_enable,
    input wire logic pers_we,
    input wire logic [key_policy_pkg::BITMAP_BITS-1:0] final_key_use_bitmap,
    input wire logic hash_start,
    input wire key_policy_pkg::hash_req_type hash_req_q,
    input wire logic slot_rd_en,
    input wire logic [key_policy_pkg::KEY_W-1:0] slot_rd_data,
    input wire logic [key_policy_pkg::KEY_W-1:0] temporary_key_register,
    input wire key_policy_pkg::temp_flags_type temp_flags_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic take;
    logic lim15;
    assign take = req_valid && req_ready && clk_en && !pers_we;
    assign lim15 = use_limit_enable && req.cmd == CMD_OTHER_CRYPTO
        && req.selector < TRANSPORT_SEL_MIN
        && req.selector[3:0] == FINAL_KEY_SLOT;

    // ============================================================
    // bitmap use
    a_exhaust_abort: assert property (take && lim15
        && final_key_use_bitmap == '0 |=> !hash_start ##1
        (!hash_start && done && result_q == RES_USE_EXHAUSTED))
        else $error("exhausted key not refused");
    a_no_refill: assert property (take
        |-> ##2 (final_key_use_bitmap & ~$past(final_key_use_bitmap, 2)) == '0)
        else $error("bitmap bit set again");
    a_single_bit: assert property (take |-> ##2
        $countones($past(final_key_use_bitmap, 2))
        <= $countones(final_key_use_bitmap) + 1)
        else $error("more than one bit consumed");
    a_rw_keep: assert property (take
        && req.cmd inside {CMD_READ, CMD_WRITE}
        |-> ##2 final_key_use_bitmap == $past(final_key_use_bitmap, 2))
        else $error("read or write changed bitmap");

    // ============================================================
    // selectors and copy
    a_bad_sel: assert property (take
        && req.selector >= TRANSPORT_SEL_MIN && req.cmd != CMD_DIGEST_GEN
        |-> ##2 done && result_q == RES_BAD_SELECTOR)
        else $error("transport selector accepted");
    // judged against the request itself, not the unit's own decode
    a_transport_flag: assert property (take
        && req.cmd == CMD_DIGEST_GEN && req.selector >= TRANSPORT_SEL_MIN
        |-> ##2 hash_start && hash_req_q.transport
        && hash_req_q.selector == $past(req.selector, 2))
        else $error("transport hash request wrong");
    a_copy_load: assert property (slot_rd_en
        |-> ##2 temporary_key_register == $past(slot_rd_data))
        else $error("copy data not loaded");
    a_copy_flags: assert property (slot_rd_en
        |-> ##2 temp_flags_q == 4'h9)
        else $error("copy flags wrong");
    a_pw_first: assert property (slot_rd_en |-> hash_req_q.password_first)
        else $error("copy hash order wrong");
endmodule // key_policy_sva

bind key_usage_policy_unit key_policy_sva chk_u (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .done(done), .result_q(result_q),
    .use_limit_enable(use_limit_enable), .pers_we(pers_we),
    .final_key_use_bitmap(final_key_use_bitmap), .hash_start(hash_start),
    .hash_req_q(hash_req_q), .slot_rd_en(slot_rd_en),
    .slot_rd_data(slot_rd_data),
    .temporary_key_register(temporary_key_register),
    .temp_flags_q(temp_flags_q)
);
`default_nettype wire

// >>> key_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// hash engine and slot store beside the policy unit
module key_far_model
    import key_policy_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] lat,
    input wire logic hash_start,
    input wire key_policy_pkg::hash_req_type hash_req_q,
    output logic hash_done,
    output logic [key_policy_pkg::KEY_W-1:0] hash_digest,
    input wire logic slot_rd_en,
    input wire logic [3:0] slot_rd_addr_q,
    output logic [key_policy_pkg::KEY_W-1:0] slot_rd_data
);
    logic [3:0] cnt_q = 4'h0;
    logic [15:0] sel_q = 16'h0000;
    initial hash_done = 1'b0;
    initial hash_digest = '0;
    initial slot_rd_data = '0;
    // digest and slot data toggle outside their valid cycle so stale data never matches
    always @(posedge clk) begin
        hash_done <= cnt_q == 4'h1 && !hash_start;
        hash_digest <= (cnt_q == 4'h1) ? {16{sel_q}} : ~hash_digest;
        slot_rd_data <= slot_rd_en ? {64{slot_rd_addr_q}} : ~slot_rd_data;
        if (hash_start) begin
            cnt_q <= lat;
            sel_q <= hash_req_q.selector;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule // key_far_model
`default_nettype wire

// >>> test_key_usage_policy_unit.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench for the key-usage policy unit
module test_key_usage_policy_unit;
    import key_policy_pkg::*;
    localparam time DLY = 2ns;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    request_type req = '0;
    logic use_limit_enable = 1'b0;
    logic [63:0] read_key_pointer = '1;
    logic config_locked = 1'b0;
    logic pers_we = 1'b0;
    logic [3:0] pers_idx = 4'h0;
    logic [7:0] pers_byte = 8'h00;
    logic temp_load = 1'b0;
    logic [255:0] temp_load_data = '0;
    temp_flags_type temp_load_flags = '0;
    logic [3:0] lat = 4'h1;
    logic req_ready, done, hash_start, hash_done, slot_rd_en;
    result_type result_q, res;
    logic [127:0] bitmap;
    hash_req_type hash_req_q;
    logic [255:0] hash_digest, slot_rd_data, temp_key, tk;
    logic [3:0] slot_rd_addr_q;
    temp_flags_type temp_flags_q;
    int n_fail = 0;
    int check_count = 0;
    int n_hash = 0;

    key_usage_policy_unit dut_u (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .done(done), .result_q(result_q),
        .use_limit_enable(use_limit_enable),
        .read_key_pointer(read_key_pointer), .config_locked(config_locked),
        .pers_we(pers_we), .pers_idx(pers_idx), .pers_byte(pers_byte),
        .final_key_use_bitmap(bitmap), .hash_start(hash_start),
        .hash_req_q(hash_req_q), .hash_done(hash_done),
        .hash_digest(hash_digest), .slot_rd_en(slot_rd_en),
        .slot_rd_addr_q(slot_rd_addr_q), .slot_rd_data(slot_rd_data),
        .temp_load(temp_load), .temp_load_data(temp_load_data),
        .temp_load_flags(temp_load_flags), .temporary_key_register(temp_key),
        .temp_flags_q(temp_flags_q)
    );
    key_far_model far_u (
        .clk(clk), .lat(lat), .hash_start(hash_start), .hash_req_q(hash_req_q),
        .hash_done(hash_done), .hash_digest(hash_digest),
        .slot_rd_en(slot_rd_en), .slot_rd_addr_q(slot_rd_addr_q),
        .slot_rd_data(slot_rd_data)
    );

    initial forever #25 clk = ~clk;
    always @(posedge clk) if (hash_start === 1'b1) n_hash++;

    // ============================================================
    // shared tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [255:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #DLY;
    endtask
    task automatic hang();
        n_fail++;
        $display("mismatch at %0t: no handshake", $time);
        final_report();
    endtask
    task automatic run(input cmd_type c, input logic [15:0] s,
        input logic [3:0] p, input logic [7:0] m, input logic ms,
        input logic [255:0] r);
        int i;
        req = '{c, s, p, m, ms, r};
        req_valid = 1'b1;
        for (i = 0; i < 50 && req_ready !== 1'b1; i++) tick();
        if (req_ready !== 1'b1) hang();
        tick();
        req_valid = 1'b0;
        for (i = 0; i < 100 && done !== 1'b1; i++) tick();
        if (done !== 1'b1) hang();
        res = result_q;
        tick();
    endtask
    // legal personalization bytes only: ff, 7f .. 01, 00
    task automatic load_map(input logic [127:0] v);
        pers_we = 1'b1;
        for (int k = 0; k < 16; k++) begin
            pers_idx = 4'(k);
            pers_byte = v[8*k+:8];
            tick();
        end
        pers_we = 1'b0;
    endtask

    // ============================================================
    // scenarios
    task automatic t_limit();
        use_limit_enable = 1'b1;
        load_map({104'h0, 8'h01, 8'h00, 8'h01});
        run(CMD_OTHER_CRYPTO, 16'h000F, 4'h0, 8'h00, 1'b0, '0);
        check(bitmap, {104'h0, 8'h01, 16'h0}, "first bit");
        run(CMD_OTHER_CRYPTO, 16'h001F, 4'h0, 8'h00, 1'b0, '0);
        check(bitmap, 128'h0, "skip empty byte");
        tk = temp_key;
        n_hash = 0;
        run(CMD_OTHER_CRYPTO, 16'h7FFF, 4'h0, 8'h00, 1'b0, '0);
        check(res, RES_USE_EXHAUSTED, "exhausted");
        check(n_hash, 0, "hash on exhausted");
        check(temp_key, tk, "temp on exhausted");
        use_limit_enable = 1'b0;
        run(CMD_OTHER_CRYPTO, 16'h000F, 4'h0, 8'h00, 1'b0, '0);
        check(res, RES_OK, "limit off");
        config_locked = 1'b1;
        load_map('1);
        check(bitmap, 128'h0, "refill");
        config_locked = 1'b0;
    endtask
    task automatic t_cmds();
        use_limit_enable = 1'b1;
        load_map({120'h0, 8'h03});
        run(CMD_READ, 16'h000F, 4'h0, 8'h00, 1'b0, '0);
        run(CMD_WRITE, 16'h000F, 4'h0, 8'h00, 1'b0, '0);
        check(bitmap, {120'h0, 8'h03}, "read write");
        // a frozen command must resume where it stopped
        req = '{CMD_READ, 16'h000F, 4'h0, 8'h00, 1'b0, '0};
        req_valid = 1'b1;
        tick();
        req_valid = 1'b0;
        clk_en = 1'b0;
        repeat (3) tick();
        clk_en = 1'b1;
        tick();
        check(done, 1'b1, "frozen read resumes");
        check(result_q, RES_OK, "frozen read result");
        tick();
        run(CMD_KEY_DERIVE, 16'h0003, 4'hF, 8'h00, 1'b0, '0);
        check(bitmap, {120'h0, 8'h01}, "parent");
        check(hash_req_q.key_slot, 4'hF, "parent slot");
        run(CMD_KEY_DERIVE, 16'h000F, 4'h3, 8'h00, 1'b0, '0);
        check(bitmap, {120'h0, 8'h01}, "target");
        // transport use only after a device nonce
        temp_load_flags = 4'h1;
        temp_load = 1'b1;
        tick();
        temp_load = 1'b0;
        for (int k = 0; k < 6; k++) begin
            run(cmd_type'(k), 16'h800F, 4'h0, 8'h00, 1'b0, '0);
            check(hash_req_q.transport, 1'b1, "transport flag");
            check(res, cmd_type'(k) == CMD_DIGEST_GEN ? RES_OK
                : RES_BAD_SELECTOR, "selector");
        end
        check(bitmap, {120'h0, 8'h01}, "transport");
    endtask
    task automatic t_copy();
        lat = 4'h9;
        temp_load_data = {32{8'hA5}};
        temp_load = 1'b1;
        tick();
        temp_load = 1'b0;
        check(temp_key, {32{8'hA5}}, "nonce");
        read_key_pointer = {4'h0, {15{4'hF}}};
        run(CMD_MAC_CHECK, 16'h400E, 4'h0, MODE_COPY_PLAIN, 1'b1,
            {16{16'h400E}});
        check(temp_key, {64{4'hF}}, "copy next slot");
        check(temp_flags_q, 4'h9, "copy flags");
        check(hash_req_q.selector, 16'h400E, "full selector");
        check(hash_req_q.password_first, 1'b1, "order");
        // password in limited key 15 itself: copy must not spend a use
        run(CMD_MAC_CHECK, 16'h000F, 4'h0, MODE_COPY_REPLAY, 1'b0,
            {16{16'h000F}});
        check(res, RES_OK, "copy on key 15");
        check(bitmap, {120'h0, 8'h01}, "copy use");
        run(CMD_MAC_CHECK, 16'h000E, 4'h0, MODE_COPY_REPLAY, 1'b0,
            {16{16'h000E}});
        check(temp_key, {64{4'hF}}, "pointer set");
        run(CMD_MAC_CHECK, 16'h000E, 4'h0, MODE_COPY_REPLAY, 1'b1, '0);
        check(res, RES_MISMATCH, "bad response");
        // slot 14 copyable from here, so a wrong copy would show as E
        read_key_pointer = {8'h00, {14{4'hF}}};
        run(CMD_MAC_CHECK, 16'h000E, 4'h0, MODE_COPY_PLAIN, 1'b0,
            {16{16'h000E}});
        check(temp_key, {64{4'hF}}, "source differs");
        run(CMD_MAC_CHECK, 16'h000E, 4'h0, 8'h04, 1'b0, {16{16'h000E}});
        check(temp_key, {64{4'hF}}, "other mode");
        run(CMD_MAC_CHECK, 16'h000E, 4'h0, MODE_COPY_REPLAY, 1'b0,
            {16{16'h000E}});
        check(temp_key, {64{4'hE}}, "copy own slot");
        check(temp_flags_q, 4'h9, "replay flags");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #DLY;
        sys_rst = 1'b0;
        t_limit();
        t_cmds();
        t_copy();
        final_report();
    end
endmodule // test_key_usage_policy_unit
`default_nettype wire
